// *** rtl/gate_cfg_pkg.sv ***
// Package with register map, field layout, reset values and timing counts.
package gate_cfg_pkg;
  // ----------------------------------------------------------------------
  // Register map (word addresses, one word each; byte address is the word address times four)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_LOCK_CTRL = 4'h3;
  localparam logic [3:0] ADDR_LOW_SIDE_GATE_DRIVE = 4'h4;
  localparam logic [3:0] ADDR_OVERCURRENT_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_FAULT_STATUS = 4'h6;
  localparam logic [3:0] ADDR_FAULT_MASK = 4'h7;
  localparam logic [3:0] ADDR_FAULT_CTRL = 4'h8;
  localparam int ADDR_W = 6;
  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CLEAR_SELECT_BIT = 10;
  localparam int RETRY_SELECT_BIT = 10;
  localparam logic [10:0] LOW_SIDE_RESET = 11'h7FF;
  localparam logic [10:0] OVERCURRENT_RESET = 11'h169;
  localparam logic [2:0] LOCK_RESET = 3'h3;
  localparam logic [2:0] LOCK_CODE = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;
  localparam logic [1:0] RESPONSE_RETRY = 2'h1;
  localparam logic [1:0] RESPONSE_LATCH = 2'h0;
  localparam logic [1:0] RESPONSE_REPORT = 2'h2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int RETRY_LONG_US = 8000;
  localparam int RETRY_SHORT_US = 50;
  localparam int RETRY_LONG_CYC = RETRY_LONG_US * (CLK_HZ / 1_000_000);
  localparam int RETRY_SHORT_CYC = RETRY_SHORT_US * (CLK_HZ / 1_000_000);
  localparam int DRIVE_BASE_NS = 500;
  localparam int DRIVE_BASE_CYC = (DRIVE_BASE_NS * (CLK_HZ / 1_000_000)
                                   + 999) / 1000;

  typedef enum logic [1:0] {
    FAULT_IDLE = 2'b00,
    FAULT_RETRY = 2'b01,
    FAULT_LATCHED = 2'b10
  } fault_state_t;

  typedef struct packed {
    logic clear_select;
    logic [1:0] peak_drive_time;
    logic [3:0] low_side_source_current;
    logic [3:0] low_side_sink_current;
  } low_side_t;

  typedef struct packed {
    logic retry_time_select;
    logic [1:0] dead_time;
    logic [1:0] overcurrent_response;
    logic [1:0] deglitch;
    logic [3:0] vds_level;
  } overcurrent_t;
endpackage : gate_cfg_pkg

// *** rtl/gate_drive_low_side_config.sv ***
// Low-side gate drive and overcurrent control registers with retry logic.
`timescale 1ns/1ps
`default_nettype none
module gate_drive_low_side_config #(
  parameter int RETRY_LONG = gate_cfg_pkg::RETRY_LONG_CYC,
  parameter int RETRY_SHORT = gate_cfg_pkg::RETRY_SHORT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [gate_cfg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Fault and PWM pins
  input wire logic [2:0] pwm_in,
  input wire logic drain_source_overcurrent,
  input wire logic shunt_sense_overcurrent,
  // Configuration to the drive stage
  output gate_cfg_pkg::low_side_t low_side_cfg,
  output gate_cfg_pkg::overcurrent_t overcurrent_cfg,
  output logic drive_active,
  output logic fault_active,
  output logic irq
);
  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [2:0] pwm_prev;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      pwm_prev <= 3'h0;
    end else begin
      sync_a <= {drain_source_overcurrent, shunt_sense_overcurrent, pwm_in};
      sync_b <= sync_a;
      pwm_prev <= sync_b[2:0];
    end
  end
  logic overcurrent;
  logic pwm_edge;
  assign overcurrent = sync_b[4] | sync_b[3];
  assign pwm_edge = |(sync_b[2:0] ^ pwm_prev);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // One wait cycle per access: reads see registered data, writes land once.
  logic ack;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end
  assign waitrequest = (read | write) & ~ack;
  logic wr_go;
  logic rd_go;
  logic [3:0] word;
  assign wr_go = write & ack & byteenable[0] & byteenable[1];
  assign rd_go = read & ack;
  assign word = address[5:2];

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [2:0] lock;
  logic locked;
  logic [2:0] status;
  logic [2:0] mask;
  assign locked = (lock == gate_cfg_pkg::LOCK_CODE);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock <= gate_cfg_pkg::LOCK_RESET;
    end else if (wr_go && word == gate_cfg_pkg::ADDR_LOCK_CTRL) begin
      // Only the two defined codes move the lock; others are ignored.
      if (!locked && writedata[2:0] == gate_cfg_pkg::LOCK_CODE) begin
        lock <= gate_cfg_pkg::LOCK_CODE;
      end else if (locked && writedata[2:0] == gate_cfg_pkg::UNLOCK_CODE) begin
        lock <= gate_cfg_pkg::UNLOCK_CODE;
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_side_cfg <= gate_cfg_pkg::LOW_SIDE_RESET;
    end else if (wr_go && !locked
                 && word == gate_cfg_pkg::ADDR_LOW_SIDE_GATE_DRIVE) begin
      low_side_cfg <= writedata[10:0];
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overcurrent_cfg <= gate_cfg_pkg::OVERCURRENT_RESET;
    end else if (wr_go && !locked
                 && word == gate_cfg_pkg::ADDR_OVERCURRENT_CONTROL) begin
      overcurrent_cfg <= writedata[10:0];
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask <= 3'h0;
    end else if (wr_go && word == gate_cfg_pkg::ADDR_FAULT_MASK) begin
      mask <= writedata[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // Fault state machine
  // ----------------------------------------------------------------------
  gate_cfg_pkg::fault_state_t state;
  logic [23:0] retry_cnt;
  logic retry_done;
  logic clear_by_pwm;
  logic soft_clear;
  logic [23:0] retry_len;
  assign retry_len = overcurrent_cfg.retry_time_select
                     ? 24'(RETRY_SHORT) : 24'(RETRY_LONG);
  assign retry_done = (retry_cnt == 24'h000001);
  assign clear_by_pwm = low_side_cfg.clear_select & pwm_edge;
  assign soft_clear = wr_go && word == gate_cfg_pkg::ADDR_FAULT_CTRL
                      && writedata[0];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= gate_cfg_pkg::FAULT_IDLE;
      retry_cnt <= 24'h000000;
    end else begin
      case (state)
        gate_cfg_pkg::FAULT_IDLE: begin
          if (overcurrent) begin
            if (overcurrent_cfg.overcurrent_response
                == gate_cfg_pkg::RESPONSE_RETRY) begin
              state <= gate_cfg_pkg::FAULT_RETRY;
              retry_cnt <= retry_len;
            end else if (overcurrent_cfg.overcurrent_response
                         == gate_cfg_pkg::RESPONSE_LATCH) begin
              state <= gate_cfg_pkg::FAULT_LATCHED;
            end
          end
        end
        gate_cfg_pkg::FAULT_RETRY: begin
          // Clear-select is consulted only here, in retry mode.
          if (retry_done || clear_by_pwm) begin
            state <= gate_cfg_pkg::FAULT_IDLE;
            retry_cnt <= 24'h000000;
          end else begin
            retry_cnt <= retry_cnt - 24'h000001;
          end
        end
        gate_cfg_pkg::FAULT_LATCHED: begin
          if (soft_clear) begin
            state <= gate_cfg_pkg::FAULT_IDLE;
          end
        end
        default: begin
          state <= gate_cfg_pkg::FAULT_IDLE;
        end
      endcase
    end
  end
  assign fault_active = (state != gate_cfg_pkg::FAULT_IDLE);

  // ----------------------------------------------------------------------
  // Peak drive timer
  // ----------------------------------------------------------------------
  // Drive window restarts on each PWM edge outside a fault; length doubles per code step.
  logic [7:0] drive_cnt;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      drive_cnt <= 8'h00;
    end else if (pwm_edge && !fault_active) begin
      drive_cnt <= 8'(gate_cfg_pkg::DRIVE_BASE_CYC
                      << low_side_cfg.peak_drive_time);
    end else if (drive_cnt != 8'h00) begin
      drive_cnt <= drive_cnt - 8'h01;
    end
  end
  assign drive_active = (drive_cnt != 8'h00);

  // ----------------------------------------------------------------------
  // Interrupt status: bit0 overcurrent detected, bit1 retry cleared, bit2 pwm clear
  // ----------------------------------------------------------------------
  logic [2:0] events;
  assign events[0] = overcurrent && state == gate_cfg_pkg::FAULT_IDLE
                     && overcurrent_cfg.overcurrent_response
                        != 2'h3;
  assign events[1] = state == gate_cfg_pkg::FAULT_RETRY && retry_done;
  assign events[2] = state == gate_cfg_pkg::FAULT_RETRY && clear_by_pwm
                     && !retry_done;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= gate_cfg_pkg::STATUS_RESET;
    end else if (rd_go && word == gate_cfg_pkg::ADDR_FAULT_STATUS) begin
      // Clear only the bits the read reported, so an event that lands
      // between the data capture and the clear is not lost.
      status <= (status & ~readdata[2:0]) | events;
    end else begin
      status <= status | events;
    end
  end
  assign irq = |(status & mask);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h00000000;
    end else if (read && !ack) begin
      if (word == gate_cfg_pkg::ADDR_LOW_SIDE_GATE_DRIVE) begin
        readdata <= {21'h000000, low_side_cfg};
      end else if (word == gate_cfg_pkg::ADDR_OVERCURRENT_CONTROL) begin
        readdata <= {21'h000000, overcurrent_cfg};
      end else if (word == gate_cfg_pkg::ADDR_LOCK_CTRL) begin
        readdata <= {29'h00000000, lock};
      end else if (word == gate_cfg_pkg::ADDR_FAULT_STATUS) begin
        readdata <= {29'h00000000, status};
      end else if (word == gate_cfg_pkg::ADDR_FAULT_MASK) begin
        readdata <= {29'h00000000, mask};
      end else if (word == gate_cfg_pkg::ADDR_FAULT_CTRL) begin
        readdata <= {30'h00000000, state};
      end else begin
        readdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  low_side_reset_a: assert property (@(posedge clk)
    $fell(reset) |-> low_side_cfg == gate_cfg_pkg::LOW_SIDE_RESET)
    else $error("Low-side register not at reset value.");
  mode_gate_a: assert property (@(posedge clk) disable iff (reset)
    state == gate_cfg_pkg::FAULT_IDLE && overcurrent
    && overcurrent_cfg.overcurrent_response != gate_cfg_pkg::RESPONSE_RETRY
    |=> state != gate_cfg_pkg::FAULT_RETRY)
    else $error("Retry entered outside retry mode.");
  timed_clear_a: assert property (@(posedge clk) disable iff (reset)
    state == gate_cfg_pkg::FAULT_RETRY && !low_side_cfg.clear_select
    && !retry_done |=> state == gate_cfg_pkg::FAULT_RETRY)
    else $error("Fault cleared before retry time.");
  pwm_clear_a: assert property (@(posedge clk) disable iff (reset)
    state == gate_cfg_pkg::FAULT_RETRY && clear_by_pwm
    |=> state == gate_cfg_pkg::FAULT_IDLE)
    else $error("PWM edge did not clear fault.");
  drive_len_a: assert property (@(posedge clk) disable iff (reset)
    pwm_edge && !fault_active && low_side_cfg.peak_drive_time == 2'h0
    ##1 !pwm_edge [*5] |=> !drive_active)
    else $error("Drive time wrong for shortest code.");
  retry_enter_a: assert property (@(posedge clk) disable iff (reset)
    state == gate_cfg_pkg::FAULT_IDLE && overcurrent
    && overcurrent_cfg.overcurrent_response == gate_cfg_pkg::RESPONSE_RETRY
    |=> state == gate_cfg_pkg::FAULT_RETRY)
    else $error("Retry mode did not start retry.");
  retry_load_a: assert property (@(posedge clk) disable iff (reset)
    $rose(state == gate_cfg_pkg::FAULT_RETRY) |->
    retry_cnt == $past(retry_len))
    else $error("Retry count loaded wrongly.");
  lock_hold_a: assert property (@(posedge clk) disable iff (reset)
    locked && !(wr_go && word == gate_cfg_pkg::ADDR_LOCK_CTRL)
    |=> $stable(low_side_cfg) && $stable(overcurrent_cfg))
    else $error("Locked register changed.");
  ocp_reset_a: assert property (@(posedge clk)
    $fell(reset) |-> overcurrent_cfg == gate_cfg_pkg::OVERCURRENT_RESET)
    else $error("Overcurrent register not at reset value.");

  // ----------------------------------------------------------------------
  // Further checks on bus, lock and fault paths
  // ----------------------------------------------------------------------
  // These guard paths that the bench reaches only rarely.
  wait_one_a: assert property (@(posedge clk) disable iff (reset)
    (read || write) && waitrequest |=> ack)
    else $error("Bus access took more than one wait cycle.");
  ls_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_go && !locked && word == gate_cfg_pkg::ADDR_LOW_SIDE_GATE_DRIVE
    |=> low_side_cfg == 11'($past(writedata)))
    else $error("Low-side write did not land.");
  ocp_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_go && !locked && word == gate_cfg_pkg::ADDR_OVERCURRENT_CONTROL
    |=> overcurrent_cfg == 11'($past(writedata)))
    else $error("Overcurrent write did not land.");
  lock_enter_a: assert property (@(posedge clk) disable iff (reset)
    !locked && wr_go && word == gate_cfg_pkg::ADDR_LOCK_CTRL
    && writedata[2:0] == gate_cfg_pkg::LOCK_CODE |=> locked)
    else $error("Lock code did not lock.");
  latch_hold_a: assert property (@(posedge clk) disable iff (reset)
    state == gate_cfg_pkg::FAULT_LATCHED && !soft_clear
    |=> state == gate_cfg_pkg::FAULT_LATCHED)
    else $error("Latched fault cleared without software.");
  report_only_a: assert property (@(posedge clk) disable iff (reset)
    state == gate_cfg_pkg::FAULT_IDLE
    && overcurrent_cfg.overcurrent_response != gate_cfg_pkg::RESPONSE_RETRY
    && overcurrent_cfg.overcurrent_response != gate_cfg_pkg::RESPONSE_LATCH
    |=> state == gate_cfg_pkg::FAULT_IDLE)
    else $error("Report-only mode entered a fault state.");
  retry_end_a: assert property (@(posedge clk) disable iff (reset)
    state == gate_cfg_pkg::FAULT_RETRY && retry_done
    |=> state == gate_cfg_pkg::FAULT_IDLE)
    else $error("Retry time elapsed but fault stayed.");
  retry_live_a: assert property (@(posedge clk) disable iff (reset)
    state == gate_cfg_pkg::FAULT_RETRY |-> retry_cnt != 24'h000000)
    else $error("Retry counter empty during retry.");
  drive_quiet_a: assert property (@(posedge clk) disable iff (reset)
    fault_active && drive_cnt == 8'h00 |=> drive_cnt == 8'h00)
    else $error("Drive timer started during a fault.");
endmodule : gate_drive_low_side_config
`default_nettype wire

// *** test/ctrl_model.sv ***
// Controller-side model that drives the PWM and overcurrent pins.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  // Clock
  input wire logic clk,
  // Pins toward the device
  output logic [2:0] pwm_in,
  output logic ds_oc,
  output logic ss_oc
);
  initial begin
    pwm_in = 3'h0;
    ds_oc = 1'b0;
    ss_oc = 1'b0;
  end
  // The pulse is short, so the pin is low again before any retry ends.
  // A fault that stays cleared then comes from the clear logic alone.
  task automatic oc_pulse(input bit shunt);
    @(posedge clk);
    if (shunt) ss_oc <= 1'b1;
    else ds_oc <= 1'b1;
    repeat (3) @(posedge clk);
    ss_oc <= 1'b0;
    ds_oc <= 1'b0;
  endtask : oc_pulse
  task automatic pwm_edge(input logic [2:0] which);
    @(posedge clk);
    pwm_in <= pwm_in ^ which;
  endtask : pwm_edge
endmodule : ctrl_model
`default_nettype wire

// *** test/test_gate_drive_low_side_config.sv ***
// Testbench for the low-side gate drive configuration registers.
`timescale 1ns/1ps
`default_nettype none
module test_gate_drive_low_side_config;
  localparam int RL = 200;
  localparam int RS = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q, d;
  logic waitrequest, ds_oc, ss_oc, drive_active, fault_active, irq;
  logic [2:0] pwm_in;
  gate_cfg_pkg::low_side_t low_side_cfg;
  gate_cfg_pkg::overcurrent_t oc_cfg;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int i, rc;
  bit locked = 1'b0;
  logic [31:0] regs [16];
  always #50 clk = ~clk;
  gate_drive_low_side_config #(.RETRY_LONG(RL), .RETRY_SHORT(RS))
    i_gate_drive_low_side_config (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .pwm_in(pwm_in),
    .drain_source_overcurrent(ds_oc), .shunt_sense_overcurrent(ss_oc),
    .low_side_cfg(low_side_cfg), .overcurrent_cfg(oc_cfg),
    .drive_active(drive_active), .fault_active(fault_active), .irq(irq));
  ctrl_model i_ctrl (.clk(clk), .pwm_in(pwm_in), .ds_oc(ds_oc),
    .ss_oc(ss_oc));
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      test_done();
    end
  end
  // ----------------------------------------------------------------------
  // Bus tasks, reference model and comparison
  // ----------------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Waitrequest and read data are taken at the rising edge itself, before
  // that edge's updates land, then the request is released.
  task automatic bus(bit w, logic [3:0] idx, logic [31:0] wd);
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= !w;
    write <= w;
    writedata <= wd;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(logic [3:0] idx, logic [31:0] wd);
    bus(1'b1, idx, wd);
    if (idx == 4'h3) begin
      if (!locked && wd[2:0] == 3'h6) locked = 1'b1;
      else if (locked && wd[2:0] == 3'h3) locked = 1'b0;
      regs[3] = locked ? 32'h6 : 32'h3;
    end else if ((idx == 4'h4 || idx == 4'h5) && !locked) regs[idx] = wd[10:0];
    else if (idx == 4'h7) regs[7] = wd[2:0];
  endtask : wr
  task automatic rd(logic [3:0] idx, string what);
    bus(1'b0, idx, 32'h0);
    chk(what, regs[idx], q);
  endtask : rd
  task automatic wait_fault(logic exp, int lim);
    for (int k = 0; k < lim && fault_active !== exp; k++) @(negedge clk);
    chk("fault_active", {31'h0, exp}, {31'h0, fault_active});
  endtask : wait_fault
  task automatic status_chk(logic [31:0] exp);
    chk("irq", 32'h1, {31'h0, irq});
    regs[6] = exp;
    rd(4'h6, "status");
    @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    regs[6] = 32'h0;
  endtask : status_chk
  task test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(97));
    foreach (regs[j]) regs[j] = 32'h0;
    regs[3] = 32'h3;
    regs[4] = 32'h7FF;
    regs[5] = 32'h169;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(4'h4, "low_side");
    rd(4'h5, "overcurrent");
    rd(4'h3, "lock");
    rd(4'hF, "unmapped");
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      d[9:8] = i[1:0];
      wr(4'h4, d);
      rd(4'h4, "low_side");
      chk("low_side_cfg", regs[4], {21'h0, low_side_cfg});
    end
    wr(4'h5, $urandom);
    rd(4'h5, "overcurrent");
    chk("overcurrent_cfg", regs[5], {21'h0, oc_cfg});
    wr(4'hF, $urandom);
    rd(4'hF, "unmapped");
    wr(4'h3, 32'h6);
    wr(4'h4, ~regs[4]);
    wr(4'h5, ~regs[5]);
    rd(4'h4, "locked low_side");
    rd(4'h5, "locked overcurrent");
    rd(4'h3, "lock");
    wr(4'h3, 32'h3);
    wr(4'h7, 32'h7);
    rd(4'h7, "mask");
    for (i = 0; i < 4; i += 3) begin
      wr(4'h4, {21'h0, 1'b0, i[1:0], 8'hFF});
      i_ctrl.pwm_edge(3'h4);
      rc = 0;
      for (int k = 0; k < 60 && !(rc > 0 && !drive_active); k++) begin
        @(posedge clk);
        if (drive_active === 1'b1) rc++;
      end
      chk("drive cycles", gate_cfg_pkg::DRIVE_BASE_CYC << i, rc);
    end
    for (i = 0; i < 2; i++) begin
      wr(4'h4, 32'h3FF);
      wr(4'h5, i[0] ? 32'h459 : 32'h059);
      rc = i[0] ? RS : RL;
      i_ctrl.oc_pulse(i[0]);
      wait_fault(1'b1, 8);
      i_ctrl.pwm_edge(3'h1 << ($urandom % 3));
      repeat (rc - 10) @(posedge clk);
      wait_fault(1'b1, 1);
      wait_fault(1'b0, 24);
      status_chk(32'h3);
    end
    wr(4'h4, 32'h7FF);
    wr(4'h5, 32'h059);
    i_ctrl.oc_pulse(1'b0);
    wait_fault(1'b1, 8);
    i_ctrl.pwm_edge(3'h1 << ($urandom % 3));
    wait_fault(1'b0, 8);
    status_chk(32'h5);
    wr(4'h5, 32'h419);
    i_ctrl.oc_pulse(1'b1);
    wait_fault(1'b1, 8);
    i_ctrl.pwm_edge(3'h2);
    repeat (RS + 10) @(posedge clk);
    wait_fault(1'b1, 1);
    wr(4'h8, 32'h1);
    wait_fault(1'b0, 4);
    wr(4'h5, 32'h499);
    i_ctrl.oc_pulse(1'b0);
    repeat (6) @(posedge clk);
    wait_fault(1'b0, 1);
    status_chk(32'h1);
    test_done();
  end
endmodule : test_gate_drive_low_side_config
`default_nettype wire
